//--- pkg/kpi_pkg.sv
package kpi_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] OFF_CTL = 8'h00;
   localparam logic [7:0] OFF_PIN_EN = 8'h04;
   localparam logic [7:0] OFF_POL = 8'h08;

   // Field positions in key_status_control
   localparam int CTL_MODE_BIT = 0;
   localparam int CTL_IRQ_EN_BIT = 1;
   localparam int CTL_ACK_BIT = 2;
   localparam int CTL_FLAG_BIT = 3;

   // Values after reset
   localparam logic [7:0] RST_PIN_EN = 8'h00;
   localparam logic [7:0] RST_POL = 8'h00;
   localparam logic RST_MODE = 1'h0;
   localparam logic RST_IRQ_EN = 1'h0;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Synchroniser depth for the key pins, in clock cycles
   localparam int SYNC_STAGES = 2;

   // Whole state of the unit, registered as one word
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [7:0] aw_addr;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic mode;
      logic irq_en;
      logic [7:0] pin_en;
      logic [7:0] pol;
      logic flag;
      logic armed;
      logic [7:0] pin_meta;
      logic [7:0] pin_sync;
      logic [7:0] prev_asserted;
      logic irq;
      logic wake;
      logic [7:0] pull_down;
   } kpi_state_t;

endpackage

//--- hdl/kpi_top.sv
// Function
// - One unit serves seven key input pins.
// - Detection continues during wait; enabled event with interrupt enabled wakes processor.
// - During stop3 an enabled event with interrupt enabled requests wake-up.
// - Deep stop disables the unit and returns registers, flag and detection state to reset; bus channel and synchroniser flops keep theirs.
// - Background debug mode changes nothing in detection or flags.
// - Status/control bits 7:4 read as zero.
// - Bit 3 is the key event flag; writes do not affect it.
// - Bit 2 is write-one acknowledge and always reads zero.
// - Bit 1 enables the interrupt request from a set flag.
// - Bit 0 selects edges only (0) or edges plus levels (1).
// - Pin enable bit 1 makes a pin a source; 0 ignores it.
// - Polarity bit 0 means falling/low, 1 means rising/high.
// - Falling edge is sample 1 then sample 0 in consecutive cycles.
// - Rising edge is sample 0 then sample 1 in consecutive cycles.
// - New edge recognised only after all enabled inputs were deasserted.
// - Edge mode: valid edge sets flag; acknowledge write clears it.
// - Level mode: valid edge or asserted level sets the flag.
// - Level mode: acknowledge clears only when every enabled input is deasserted.
// - Pull direction follows polarity: 0 pull-up, 1 pull-down.
module kpi_top #(
   parameter int NUM_PINS = 7,
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [NUM_PINS-1:0] key_input_pin,
   input wire logic stop3_mode,
   input wire logic deep_stop,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic key_irq,
   output logic key_wake_req,
   output logic [NUM_PINS-1:0] key_pull_down
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   initial
   begin
      if (NUM_PINS < 1 || NUM_PINS > 8)
      begin
         $error("NUM_PINS must be 1 to 8");
      end
      if (ADDR_W < 8)
      begin
         $error("ADDR_W must be at least 8");
      end
   end

   // Pins beyond NUM_PINS never exist, so their enable bits stay zero
   localparam logic [8:0] PIN_ONE = 9'h001;
   localparam logic [7:0] PIN_MASK = 8'((PIN_ONE << NUM_PINS) - PIN_ONE);

   ////////////////////////////////////////////////////////////////////////////
   // State and helper terms

   kpi_pkg::kpi_state_t st_reg;
   kpi_pkg::kpi_state_t st_next;
   logic [7:0] asserted;
   logic any_asserted;
   logic edge_hit;
   logic level_hit;
   logic ack_wr;
   logic wr_fire;
   logic [7:0] rd_val;
   logic [1:0] rd_resp;
   logic [1:0] wr_resp;

   // Protection bits carry no meaning for this unit
   logic prot_unused;
   assign prot_unused = ^{s_axi_awprot, s_axi_arprot, s_axi_wstrb[3:1], s_axi_wdata[31:8]};

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb
   begin
      st_next = st_reg;

      // Two flops before any logic looks at the pins
      st_next.pin_meta = 8'(key_input_pin);
      st_next.pin_sync = st_reg.pin_meta;

      // An enabled pin is asserted when its level equals its polarity
      asserted = st_reg.pin_en & ~(st_reg.pin_sync ^ st_reg.pol);
      any_asserted = |asserted;
      // Edge: deasserted sample then asserted sample, only while armed
      edge_hit = st_reg.armed & (|(asserted & ~st_reg.prev_asserted));
      level_hit = st_reg.mode & any_asserted;
      st_next.prev_asserted = asserted;

      // Disarm on an edge; rearm once every enabled input is back idle
      if (edge_hit)
      begin
         st_next.armed = 1'h0;
      end
      else if (!any_asserted)
      begin
         st_next.armed = 1'h1;
      end

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && st_reg.awready)
      begin
         st_next.aw_have = 1'h1;
         st_next.aw_addr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && st_reg.wready)
      begin
         st_next.w_have = 1'h1;
         st_next.wdata = s_axi_wdata[7:0];
         st_next.wstrb0 = s_axi_wstrb[0];
      end

      wr_fire = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;
      // Decode the held address; anything unmapped answers with an error
      wr_resp = kpi_pkg::RESP_SLVERR;
      case (st_reg.aw_addr)
         kpi_pkg::OFF_CTL,
         kpi_pkg::OFF_PIN_EN,
         kpi_pkg::OFF_POL: wr_resp = kpi_pkg::RESP_OKAY;
         default: wr_resp = kpi_pkg::RESP_SLVERR;
      endcase
      ack_wr = 1'h0;

      // Register writes; only byte lane 0 carries data
      if (wr_fire)
      begin
         st_next.aw_have = 1'h0;
         st_next.w_have = 1'h0;
         st_next.bvalid = 1'h1;
         st_next.bresp = wr_resp;
         if (st_reg.wstrb0)
         begin
            case (st_reg.aw_addr)
               kpi_pkg::OFF_CTL:
               begin
                  // Flag bit ignored on write; ack bit is a request only
                  st_next.mode = st_reg.wdata[kpi_pkg::CTL_MODE_BIT];
                  st_next.irq_en = st_reg.wdata[kpi_pkg::CTL_IRQ_EN_BIT];
                  ack_wr = st_reg.wdata[kpi_pkg::CTL_ACK_BIT];
               end
               kpi_pkg::OFF_PIN_EN: st_next.pin_en = st_reg.wdata & PIN_MASK;
               kpi_pkg::OFF_POL: st_next.pol = st_reg.wdata & PIN_MASK;
               default: st_next.bresp = kpi_pkg::RESP_SLVERR;
            endcase
         end
      end
      if (st_reg.bvalid && s_axi_bready)
      begin
         st_next.bvalid = 1'h0;
      end
      st_next.awready = !st_next.aw_have && !st_next.bvalid;
      st_next.wready = !st_next.w_have && !st_next.bvalid;

      // Flag: clear on ack, level mode only when inputs idle; a set wins
      if (ack_wr && !(st_reg.mode && any_asserted))
      begin
         st_next.flag = 1'h0;
      end
      if (edge_hit || level_hit)
      begin
         st_next.flag = 1'h1;
      end

      // Read decode; reserved and ack bits return zero
      rd_val = 8'h00;
      rd_resp = kpi_pkg::RESP_OKAY;
      if (s_axi_araddr == ADDR_W'(kpi_pkg::OFF_CTL))
      begin
         rd_val[kpi_pkg::CTL_FLAG_BIT] = st_reg.flag;
         rd_val[kpi_pkg::CTL_IRQ_EN_BIT] = st_reg.irq_en;
         rd_val[kpi_pkg::CTL_MODE_BIT] = st_reg.mode;
      end
      else if (s_axi_araddr == ADDR_W'(kpi_pkg::OFF_PIN_EN))
      begin
         rd_val = st_reg.pin_en;
      end
      else if (s_axi_araddr == ADDR_W'(kpi_pkg::OFF_POL))
      begin
         rd_val = st_reg.pol;
      end
      else
      begin
         rd_resp = kpi_pkg::RESP_SLVERR;
      end

      // Read channel
      if (s_axi_arvalid && st_reg.arready)
      begin
         st_next.rvalid = 1'h1;
         st_next.rdata = {24'h000000, rd_val};
         st_next.rresp = rd_resp;
      end
      else if (st_reg.rvalid && s_axi_rready)
      begin
         st_next.rvalid = 1'h0;
      end
      st_next.arready = !st_next.rvalid;

      // Interrupt and wake requests are registered from the flag's next value, so they change in the same cycle as the flag
      st_next.irq = st_next.flag & st_next.irq_en;
      // In stop3 the bus clock is assumed still running to this flop;
      // true clockless wake is left to the chip's power controller
      st_next.wake = stop3_mode & st_next.flag & st_next.irq_en;
      st_next.pull_down = st_next.pol;

      // Deep stop puts registers, flag and detection state back to reset; bus channels are left alone
      if (deep_stop)
      begin
         st_next.mode = kpi_pkg::RST_MODE;
         st_next.irq_en = kpi_pkg::RST_IRQ_EN;
         st_next.pin_en = kpi_pkg::RST_PIN_EN;
         st_next.pol = kpi_pkg::RST_POL;
         st_next.flag = 1'h0;
         st_next.armed = 1'h0;
         st_next.prev_asserted = 8'h00;
         st_next.irq = 1'h0;
         st_next.wake = 1'h0;
         st_next.pull_down = kpi_pkg::RST_POL;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; no debug or wait gating, detection never pauses

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg <= '0;
         st_reg.awready <= 1'h1;
         st_reg.wready <= 1'h1;
         st_reg.arready <= 1'h1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops

   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign key_irq = st_reg.irq;
   assign key_wake_req = st_reg.wake;
   assign key_pull_down = st_reg.pull_down[NUM_PINS-1:0];

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   property p_edge_sets_flag;
      @(posedge clk) disable iff (!rst_b)
      (edge_hit && !deep_stop) |=> st_reg.flag;
   endproperty
   a_edge_sets_flag: assert property (p_edge_sets_flag) else $error("edge did not set flag");

   property p_irq_follows_flag;
      @(posedge clk) disable iff (!rst_b)
      (st_reg.flag && st_reg.irq_en && !deep_stop) |=> ##0 (key_irq == (st_reg.flag && st_reg.irq_en));
   endproperty
   a_irq_follows_flag: assert property (p_irq_follows_flag) else $error("irq not matching flag");

   property p_edge_ack_clears;
      @(posedge clk) disable iff (!rst_b)
      (ack_wr && !st_reg.mode && !edge_hit) |=> !st_reg.flag;
   endproperty
   a_edge_ack_clears: assert property (p_edge_ack_clears) else $error("ack left flag set");

   property p_level_ack_holds;
      @(posedge clk) disable iff (!rst_b)
      (ack_wr && st_reg.mode && any_asserted && !deep_stop) |=> st_reg.flag;
   endproperty
   a_level_ack_holds: assert property (p_level_ack_holds) else $error("flag cleared while asserted");

   property p_ctl_read_zero;
      @(posedge clk) disable iff (!rst_b)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'(kpi_pkg::OFF_CTL))
      |=> (s_axi_rvalid && s_axi_rdata[7:4] == 4'h0 && !s_axi_rdata[2]);
   endproperty
   a_ctl_read_zero: assert property (p_ctl_read_zero) else $error("reserved bits read nonzero");

   property p_disabled_quiet;
      @(posedge clk) disable iff (!rst_b)
      (st_reg.pin_en == 8'h00 && !st_reg.flag) |=> !st_reg.flag;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("flag set with no pin enabled");

   property p_no_edge_until_idle;
      @(posedge clk) disable iff (!rst_b)
      edge_hit |=> !edge_hit;
   endproperty
   a_no_edge_until_idle: assert property (p_no_edge_until_idle) else $error("edge without rearm");

   property p_deep_stop_reset;
      @(posedge clk) disable iff (!rst_b)
      deep_stop |=> (st_reg.pin_en == 8'h00 && !st_reg.flag && !key_irq && !key_wake_req);
   endproperty
   a_deep_stop_reset: assert property (p_deep_stop_reset) else $error("deep stop kept state");

   property p_level_sets;
      @(posedge clk) disable iff (!rst_b)
      (st_reg.mode && any_asserted && !deep_stop) |=> (st_reg.flag && (key_irq || !st_reg.irq_en));
   endproperty
   a_level_sets: assert property (p_level_sets) else $error("level did not raise irq");

   property p_bresp_stable;
      @(posedge clk) disable iff (!rst_b)
      (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
   endproperty
   a_bresp_stable: assert property (p_bresp_stable) else $error("write response dropped");

endmodule

//--- verification/kpi_keys.sv
module kpi_keys (
   input wire logic clk,
   input wire logic [6:0] want,
   input wire logic [6:0] float_mask,
   input wire logic slow,
   input wire logic [6:0] pull_down,
   output logic [6:0] pins
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [6:0] d1;
   logic [6:0] d2;
   logic [6:0] d3;
   ////////////////////////////////////////
   // Contacts settle one cycle after a command, or three when slow
   always @(posedge clk)
   begin
      d1 <= want;
      d2 <= d1;
      d3 <= d2;
   end
   // A floating pin sits at its resistor level, never at the last driven value
   always_comb
   begin
      for (int i = 0; i < 7; i++)
      begin
         pins[i] = float_mask[i] ? ~pull_down[i] : (slow ? d3[i] : d1[i]);
      end
   end
endmodule

//--- verification/kpi_top_test.sv
module kpi_top_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [7:0] CTL = kpi_pkg::OFF_CTL;
   localparam logic [7:0] PEN = kpi_pkg::OFF_PIN_EN;
   localparam logic [7:0] POL = kpi_pkg::OFF_POL;
   logic clk, rst_b, stop3_mode, deep_stop, slow;
   logic [6:0] want, float_mask, key_input_pin, key_pull_down;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, key_irq, key_wake_req;
   logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0] s_axi_wstrb;
   logic [33:0] exp_r[$];
   logic [1:0] exp_b[$];
   int seed = 32'h9210b595;
   int n_fail = 0;
   int tests_run = 0;

   kpi_top dut_u (.clk(clk), .rst_b(rst_b), .key_input_pin(key_input_pin), .stop3_mode(stop3_mode),
      .deep_stop(deep_stop), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .key_irq(key_irq), .key_wake_req(key_wake_req), .key_pull_down(key_pull_down));
   kpi_keys keys_u (.clk(clk), .want(want), .float_mask(float_mask), .slow(slow),
      .pull_down(key_pull_down), .pins(key_input_pin));
   ////////////////////////////////////////
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Both write channels offered together; each dropped once taken
   // Lane 0 strobe low must leave the register untouched
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = kpi_pkg::RESP_OKAY,
      input logic s0 = 1'b1);
      logic a_ok;
      logic w_ok;
      a_ok = 1'b0;
      w_ok = 1'b0;
      exp_b.push_back(er);
      rnd = $random(seed);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {rnd[31:8], d};
      s_axi_wstrb <= {rnd[2:0], s0};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(a_ok && w_ok))
      begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            a_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] d);
      exp_r.push_back({24'h0, d, kpi_pkg::RESP_OKAY});
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   // Covers two bus cycles of sync plus the slow contact delay
   task automatic keys(input logic [6:0] w);
      want <= w;
      repeat (8) @(posedge clk);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////
   // Responses are matched to the oldest note in order of arrival
   always @(posedge clk)
   begin
      if (s_axi_bvalid && s_axi_bready)
         chk({32'h0, s_axi_bresp}, {32'h0, exp_b.pop_front()});
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rdata, s_axi_rresp}, exp_r.pop_front());
   end
   // 40 MHz bus clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Generous bound; the whole sequence needs under two thousand cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end
   // Main sequence
   initial
   begin
      {rst_b, stop3_mode, deep_stop, slow, float_mask} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      want = 7'h7b;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rd(CTL, 8'h00);
      rd(PEN, 8'h00);
      rd(POL, 8'h00);
      wr(8'h0c, 8'hff, kpi_pkg::RESP_SLVERR);
      wr(CTL, 8'hf8);
      rd(CTL, 8'h00);
      $display("test reset done");
      wr(POL, 8'hd4);
      rd(POL, 8'h54);
      wr(POL, 8'h2a, kpi_pkg::RESP_OKAY, 1'b0);
      rd(POL, 8'h54);
      chk({27'h0, key_pull_down}, {27'h0, 7'h54});
      wr(PEN, 8'h01);
      wr(CTL, 8'h04);
      wr(CTL, 8'h02);
      for (int i = 0; i < 4; i++)
      begin
         rnd = $random(seed);
         keys({rnd[6:1], 1'b1});
      end
      keys(7'h7b);
      rd(CTL, 8'h02);
      keys(7'h7a);
      rd(CTL, 8'h0a);
      #1;
      chk({33'h0, key_irq}, {33'h0, 1'b1});
      wr(CTL, 8'h06);
      rd(CTL, 8'h02);
      $display("test edge done");
      wr(CTL, 8'h03);
      rd(CTL, 8'h0b);
      wr(CTL, 8'h07);
      rd(CTL, 8'h0b);
      keys(7'h7b);
      wr(CTL, 8'h07);
      rd(CTL, 8'h03);
      $display("test level done");
      wr(CTL, 8'h06);
      slow <= 1'b1;
      float_mask <= 7'h04;
      wr(PEN, 8'h05);
      wr(CTL, 8'h06);
      rd(CTL, 8'h02);
      float_mask <= 7'h00;
      keys(7'h7f);
      rd(CTL, 8'h0a);
      chk({33'h0, key_wake_req}, 34'h0);
      stop3_mode <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk({33'h0, key_wake_req}, {33'h0, 1'b1});
      $display("test rising done");
      @(posedge clk);
      stop3_mode <= 1'b0;
      deep_stop <= 1'b1;
      @(posedge clk);
      deep_stop <= 1'b0;
      rd(CTL, 8'h00);
      rd(PEN, 8'h00);
      rd(POL, 8'h00);
      #1;
      chk({25'h0, key_wake_req, key_irq, key_pull_down}, 34'h0);
      $display("test deep stop done");
      repeat (2) @(posedge clk);
      summarize();
   end
endmodule
